// [inc/dpf_pkg.sv]
`default_nettype none
// Shared constants for the dual pin PWM / square wave block
package dpf_pkg;
  // Clock and timebase
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned TICK_PERIOD_NS = 1000;
  // Least time rounds up to whole cycles
  localparam int unsigned TICK_CYCLES = (TICK_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [7:0] TICK_CNT_LAST = 8'(TICK_CYCLES - 1);
  localparam logic [31:0] CLK_HZ = 32'h0ee6_b280;     // 250 MHz
  localparam logic [31:0] SQ_MAX_HZ = 32'h003d_0900;  // 4 MHz

  // Register byte addresses
  localparam logic [7:0] ADDR_CTRL = 8'h00;
  localparam logic [7:0] ADDR_PERIOD = 8'h04;
  localparam logic [7:0] ADDR_DUTY0 = 8'h08;
  localparam logic [7:0] ADDR_DUTY1 = 8'h0c;
  localparam logic [7:0] ADDR_SQFREQ = 8'h10;
  localparam logic [7:0] ADDR_STATUS = 8'h14;
  localparam logic [7:0] ADDR_COUNT = 8'h18;

  // Control field layout: two bits of pin function per pin
  localparam int unsigned CTRL_FUNC_W = 2;
  localparam int unsigned CTRL_W = 4;

  // Reset values
  localparam logic [3:0] CTRL_RST = 4'h0;
  // Short reset period so the first boundary comes soon after reset
  localparam logic [31:0] PERIOD_RST = 32'h0000_0064;
  localparam logic [31:0] DUTY_RST = 32'h0000_0000;
  localparam logic [31:0] SQFREQ_RST = 32'h0000_0000;

  // Pin function select encodings
  typedef enum logic [1:0] {
    DPF_FN_OFF,
    DPF_FN_PWM,
    DPF_FN_SQ,
    DPF_FN_RSVD
  } dpf_func_t;

  // Pin function of one pin out of the control word
  function automatic dpf_func_t dpf_pin_func(input logic [3:0] ctrl, input int idx);
    dpf_pin_func = dpf_func_t'(ctrl[CTRL_FUNC_W*idx +: CTRL_FUNC_W]);
  endfunction

  // A period of zero runs at the fastest rate, one timebase step
  function automatic logic [31:0] dpf_eff_period(input logic [31:0] p);
    dpf_eff_period = (p == 32'h0) ? 32'h0000_0001 : p;
  endfunction
endpackage
`default_nettype wire

// [inc/dpf_link_if.sv]
`timescale 1ns/1ns
`default_nettype none
// Carries the timebase tick and the square wave between the block's modules
interface dpf_link_if (
  input wire logic clock,
  input wire logic rst_b
);
  logic tick;
  logic [31:0] sq_square_wave_output;
  logic sq_wave;
  modport tick_src (input clock, input rst_b, output tick);
  modport sq_gen (input clock, input rst_b, input sq_square_wave_output, output sq_wave);
  modport core (input tick, input sq_wave, output sq_square_wave_output);
endinterface
`default_nettype wire

// [design/dpf_tick_gen.sv]
`timescale 1ns/1ns
`default_nettype none
// One cycle enable at 1 MHz out of the 250 MHz clock
module dpf_tick_gen (
  // Link to the core
  dpf_link_if.tick_src link
);
  typedef struct packed {
    logic [7:0] cnt;
    logic tick;
  } dpf_tick_state_t;

  dpf_tick_state_t st_reg;
  dpf_tick_state_t st_next;

  // Divider: the tick is registered so the core sees a clean pulse
  always_comb begin
    st_next = st_reg;
    st_next.tick = 1'b0;
    if (st_reg.cnt == dpf_pkg::TICK_CNT_LAST) begin
      st_next.cnt = 8'h00;
      st_next.tick = 1'b1;
    end else begin
      st_next.cnt = st_reg.cnt + 8'h01;
    end
  end

  // State register
  always_ff @(posedge link.clock or negedge link.rst_b) begin
    if (!link.rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.tick = st_reg.tick;

  default clocking dpf_cb @(posedge link.clock); endclocking
  default disable iff (!link.rst_b);

  tick_period_a: assert property (link.tick |-> ##250 link.tick)
    else $error("Timebase tick not every 250 cycles");
  tick_single_a: assert property (link.tick |=> !link.tick [*8])
    else $error("Timebase tick longer than one cycle");
endmodule
`default_nettype wire

// [design/dpf_sqwave.sv]
`timescale 1ns/1ns
`default_nettype none
// Square wave from a rate accumulator; each edge adds twice the frequency
module dpf_sqwave (
  // Link to the core
  dpf_link_if.sq_gen link
);
  typedef struct packed {
    logic [31:0] acc;
    logic wave;
    logic [7:0] hold;
  } dpf_sq_state_t;

  dpf_sq_state_t st_reg;
  dpf_sq_state_t st_next;
  logic [31:0] square_wave_output_clamped;
  logic [31:0] sum;

  // Frequencies above the top rate are clamped so high and low never drop under 31 cycles
  assign square_wave_output_clamped = (link.sq_square_wave_output > dpf_pkg::SQ_MAX_HZ) ? dpf_pkg::SQ_MAX_HZ : link.sq_square_wave_output;
  assign sum = st_reg.acc + {square_wave_output_clamped[30:0], 1'b0};

  // Toggle each time the accumulator passes the clock rate; average mark-space is even
  always_comb begin
    st_next = st_reg;
    if (link.sq_square_wave_output == 32'h0) begin
      st_next.acc = 32'h0;
      st_next.wave = 1'b0;
    end else if (sum >= dpf_pkg::CLK_HZ) begin
      st_next.acc = sum - dpf_pkg::CLK_HZ;
      st_next.wave = ~st_reg.wave;
    end else begin
      st_next.acc = sum;
    end
    // Level age, saturating; only the checks read it
    if (st_next.wave != st_reg.wave) begin
      st_next.hold = 8'h00;
    end else if (st_reg.hold != 8'hff) begin
      st_next.hold = st_reg.hold + 8'h01;
    end
  end

  // State register
  always_ff @(posedge link.clock or negedge link.rst_b) begin
    if (!link.rst_b) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign link.sq_wave = st_reg.wave;

  default clocking dpf_cb @(posedge link.clock); endclocking
  default disable iff (!link.rst_b);

  sq_static_a: assert property (link.sq_square_wave_output == 32'h0 |=> !link.sq_wave)
    else $error("Square wave not static at zero frequency");
  // A stop to zero frequency cuts the level short on purpose, so it is left out
  sq_min_level_a: assert property ($changed(link.sq_wave) && $past(link.sq_square_wave_output) != 32'h0
    |-> $past(st_reg.hold) >= 8'h1e)
    else $error("Square wave level shorter than 31 cycles");
  sq_run_c: cover property ($rose(link.sq_wave) ##[1:300] $fell(link.sq_wave));
endmodule
`default_nettype wire

// [design/dpf_core.sv]
`timescale 1ns/1ns
`default_nettype none
// How it works
// - Each of two pins carries PWM, square wave or nothing, chosen by software.
// - PWM period counter and compare values are 32 bits wide.
// - PWM counter advances once per 1 MHz timebase tick.
// - Software sets PWM period in ticks; one tick gives the 1 MHz top rate.
// - Duty zero holds the pin low; a nonzero duty at or above period holds it high.
// - Both pins share one period; each pin has its own duty value.
// - Square wave runs 0 Hz to 4 MHz with high and low times equal on average (31 and 32 cycles at 4 MHz).
module dpf_core (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_b,
  // Register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  // General purpose pins
  output logic [1:0] general_purpose_pin_out,
  output logic [1:0] general_purpose_pin_oe
);
  typedef struct packed {
    logic [3:0] ctrl;
    logic [31:0] period;
    logic [1:0][31:0] duty;
    logic [31:0] sqfreq;
    logic [31:0] act_period;
    logic [1:0][31:0] act_duty;
    logic [31:0] cnt;
    logic [1:0] pin_out;
    logic [1:0] pin_oe;
    logic [31:0] rdata;
  } dpf_core_state_t;

  dpf_core_state_t st_reg;
  dpf_core_state_t st_next;

  // Timebase and square wave helpers share one link
  dpf_link_if link (
    .clock(clock),
    .rst_b(rst_b)
  );

  dpf_tick_gen u_tick (
    .link(link)
  );

  dpf_sqwave u_sq (
    .link(link)
  );

  assign link.sq_square_wave_output = st_reg.sqfreq;

  // Register writes, read answer, PWM counter and pin routing
  always_comb begin
    st_next = st_reg;
    // Read data stand for one cycle only, zero otherwise
    st_next.rdata = 32'h0;

    if (reg_wr) begin
      case (reg_addr)
        dpf_pkg::ADDR_CTRL: begin
          st_next.ctrl = reg_wdata[dpf_pkg::CTRL_W-1:0];
        end
        dpf_pkg::ADDR_PERIOD: begin
          st_next.period = reg_wdata;
        end
        dpf_pkg::ADDR_DUTY0: begin
          st_next.duty[0] = reg_wdata;
        end
        dpf_pkg::ADDR_DUTY1: begin
          st_next.duty[1] = reg_wdata;
        end
        dpf_pkg::ADDR_SQFREQ: begin
          st_next.sqfreq = reg_wdata;
        end
        default: begin
        end
      endcase
    end

    if (reg_rd) begin
      case (reg_addr)
        dpf_pkg::ADDR_CTRL: begin
          st_next.rdata = {28'h0, st_reg.ctrl};
        end
        dpf_pkg::ADDR_PERIOD: begin
          st_next.rdata = st_reg.period;
        end
        dpf_pkg::ADDR_DUTY0: begin
          st_next.rdata = st_reg.duty[0];
        end
        dpf_pkg::ADDR_DUTY1: begin
          st_next.rdata = st_reg.duty[1];
        end
        dpf_pkg::ADDR_SQFREQ: begin
          st_next.rdata = st_reg.sqfreq;
        end
        dpf_pkg::ADDR_STATUS: begin
          st_next.rdata = {27'h0, st_reg.pin_oe, st_reg.pin_out, link.sq_wave};
        end
        dpf_pkg::ADDR_COUNT: begin
          st_next.rdata = st_reg.cnt;
        end
        default: begin
          st_next.rdata = 32'h0;
        end
      endcase
    end

    // Counter moves only on the tick
    if (link.tick) begin
      // Reload at the boundary so a new setting never cuts a period short
      if (st_reg.cnt + 32'h1 >= dpf_pkg::dpf_eff_period(st_reg.act_period)) begin
        st_next.cnt = 32'h0;
        st_next.act_period = st_next.period;
        st_next.act_duty = st_next.duty;
      end else begin
        st_next.cnt = st_reg.cnt + 32'h1;
      end
    end

    // Route each pin; a pin not given a function is released
    for (int i = 0; i < 2; i++) begin
      case (dpf_pkg::dpf_pin_func(st_next.ctrl, i))
        dpf_pkg::DPF_FN_PWM: begin
          // Compare against own duty; duty above period stays high
          st_next.pin_out[i] = st_next.cnt < st_next.act_duty[i];
          st_next.pin_oe[i] = 1'b1;
        end
        dpf_pkg::DPF_FN_SQ: begin
          // Square wave passed straight to the pin
          st_next.pin_out[i] = link.sq_wave;
          st_next.pin_oe[i] = 1'b1;
        end
        default: begin
          st_next.pin_out[i] = 1'b0;
          st_next.pin_oe[i] = 1'b0;
        end
      endcase
    end
  end

  // State register
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      st_reg.ctrl <= dpf_pkg::CTRL_RST;
      st_reg.period <= dpf_pkg::PERIOD_RST;
      st_reg.duty <= {dpf_pkg::DUTY_RST, dpf_pkg::DUTY_RST};
      st_reg.sqfreq <= dpf_pkg::SQFREQ_RST;
      st_reg.act_period <= dpf_pkg::PERIOD_RST;
      st_reg.act_duty <= {dpf_pkg::DUTY_RST, dpf_pkg::DUTY_RST};
      st_reg.cnt <= 32'h0;
      st_reg.pin_out <= 2'h0;
      st_reg.pin_oe <= 2'h0;
      st_reg.rdata <= 32'h0;
    end else begin
      st_reg <= st_next;
    end
  end

  // Outputs straight from the state register
  assign reg_rdata = st_reg.rdata;
  assign general_purpose_pin_out = st_reg.pin_out;
  assign general_purpose_pin_oe = st_reg.pin_oe;

  default clocking dpf_cb @(posedge clock); endclocking
  default disable iff (!rst_b);

  pin_off_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_OFF
      |-> !general_purpose_pin_oe[0] && !general_purpose_pin_out[0])
    else $error("Unused pin 0 still driven");
  cnt_bound_a: assert property (
    st_reg.cnt < dpf_pkg::dpf_eff_period(st_reg.act_period))
    else $error("Period counter beyond active period");
  cnt_hold_a: assert property (!link.tick |=> $stable(st_reg.cnt))
    else $error("Period counter moved without a tick");
  period_one_a: assert property (
    st_reg.act_period == 32'h1 && link.tick |=> st_reg.cnt == 32'h0)
    else $error("Single step period did not wrap");
  duty_zero_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_PWM && st_reg.act_duty[1] == 32'h0
      |-> general_purpose_pin_oe[1] && !general_purpose_pin_out[1])
    else $error("Zero duty pin not held low");
  duty_full_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_PWM
      && st_reg.act_duty[0] >= dpf_pkg::dpf_eff_period(st_reg.act_period)
      |-> general_purpose_pin_out[0])
    else $error("Full duty pin not held high");
  shared_period_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_PWM
      && dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_PWM
      && st_reg.act_duty[0] == st_reg.act_duty[1]
      |-> general_purpose_pin_out[0] == general_purpose_pin_out[1])
    else $error("Pins with equal duty disagree");
  sq_route_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_SQ
      |-> general_purpose_pin_out[1] == $past(link.sq_wave))
    else $error("Square wave not routed to pin 1");
  reload_edge_a: assert property (
    $changed(st_reg.act_period) || $changed(st_reg.act_duty) |-> st_reg.cnt == 32'h0)
    else $error("Active values changed inside a period");
  pwm_compare_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_PWM
      |-> general_purpose_pin_out[0] == (st_reg.cnt < st_reg.act_duty[0]))
    else $error("Pin 0 level does not match compare");
  read_once_a: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("Read data outside the answer cycle");

  // Pin 1 mirrors the pin 0 off check; the enable check below guards pin 0 only
  pin1_off_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_OFF
      |-> !general_purpose_pin_oe[1] && !general_purpose_pin_out[1])
    else $error("Unused pin 1 still driven");

  // Enable follows the function code; the spare code releases the pin
  pin0_enable_a: assert property (
    general_purpose_pin_oe[0] == (dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_PWM
      || dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_SQ))
    else $error("Pin 0 enable does not follow its function");

  // Square wave may sit on either pin
  sq_route0_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_SQ
      |-> general_purpose_pin_out[0] == $past(link.sq_wave))
    else $error("Square wave not routed to pin 0");

  // Pin 1 compare against its own duty
  pwm_compare1_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_PWM
      |-> general_purpose_pin_out[1] == (st_reg.cnt < st_reg.act_duty[1]))
    else $error("Pin 1 level does not match compare");

  // Duty ends on pin 0 and pin 1 in the other sense
  duty_zero0_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 0) == dpf_pkg::DPF_FN_PWM && st_reg.act_duty[0] == 32'h0
      |-> general_purpose_pin_oe[0] && !general_purpose_pin_out[0])
    else $error("Zero duty pin 0 not held low");
  duty_full1_a: assert property (
    dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_PWM
      && st_reg.act_duty[1] >= dpf_pkg::dpf_eff_period(st_reg.act_period)
      |-> general_purpose_pin_out[1])
    else $error("Full duty pin 1 not held high");

  // Counter steps by one inside a period and wraps at its end
  cnt_step_a: assert property (
    link.tick && st_reg.cnt + 32'h1 < dpf_pkg::dpf_eff_period(st_reg.act_period)
      |=> st_reg.cnt == $past(st_reg.cnt) + 32'h1)
    else $error("Period counter did not step on a tick");
  cnt_wrap_a: assert property (
    link.tick && st_reg.cnt + 32'h1 >= dpf_pkg::dpf_eff_period(st_reg.act_period)
      |=> st_reg.cnt == 32'h0)
    else $error("Period counter did not wrap at the boundary");

  // Settings load at the boundary; a write in the same cycle is left out
  act_reload_a: assert property (
    link.tick && !reg_wr && st_reg.cnt + 32'h1 >= dpf_pkg::dpf_eff_period(st_reg.act_period)
      |=> st_reg.act_period == $past(st_reg.period) && st_reg.act_duty == $past(st_reg.duty))
    else $error("Active values not loaded at the boundary");
  act_hold_a: assert property (
    !link.tick |=> $stable(st_reg.act_period) && $stable(st_reg.act_duty))
    else $error("Active values changed without a tick");

  // Writes land in the cycle after the strobe
  ctrl_write_a: assert property (
    reg_wr && reg_addr == dpf_pkg::ADDR_CTRL
      |=> st_reg.ctrl == $past(reg_wdata[dpf_pkg::CTRL_W-1:0]))
    else $error("Function select write lost");
  period_write_a: assert property (
    reg_wr && reg_addr == dpf_pkg::ADDR_PERIOD |=> st_reg.period == $past(reg_wdata))
    else $error("Period write lost");
  duty0_write_a: assert property (
    reg_wr && reg_addr == dpf_pkg::ADDR_DUTY0 |=> st_reg.duty[0] == $past(reg_wdata))
    else $error("Pin 0 duty write lost");
  duty1_write_a: assert property (
    reg_wr && reg_addr == dpf_pkg::ADDR_DUTY1 |=> st_reg.duty[1] == $past(reg_wdata))
    else $error("Pin 1 duty write lost");
  sqfreq_write_a: assert property (
    reg_wr && reg_addr == dpf_pkg::ADDR_SQFREQ |=> st_reg.sqfreq == $past(reg_wdata))
    else $error("Square rate write lost");

  // Read answers carry the value held at the strobe; unmapped reads answer zero
  read_period_a: assert property (
    reg_rd && reg_addr == dpf_pkg::ADDR_PERIOD |=> reg_rdata == $past(st_reg.period))
    else $error("Period read answer wrong");
  read_count_a: assert property (
    reg_rd && reg_addr == dpf_pkg::ADDR_COUNT |=> reg_rdata == $past(st_reg.cnt))
    else $error("Counter read answer wrong");
  read_unmapped_a: assert property (
    reg_rd && reg_addr > dpf_pkg::ADDR_COUNT |=> reg_rdata == 32'h0)
    else $error("Unmapped read not zero");

  both_pwm_c: cover property (general_purpose_pin_out == 2'h3 ##[1:1000]
    general_purpose_pin_out == 2'h1);
  reload_c: cover property ($changed(st_reg.act_period));
  sq_pin_c: cover property (dpf_pkg::dpf_pin_func(st_reg.ctrl, 1) == dpf_pkg::DPF_FN_SQ
    && $rose(general_purpose_pin_out[1]));
endmodule
`default_nettype wire

// [test/dual_pin_pwm_square_wave_output_output_tb.sv]
`timescale 1ns/1ns
`default_nettype none
module dual_pin_pwm_square_wave_output_output_tb;
  // Bench side of the block's ports
  logic clock = 1'b0;
  logic rst_b;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [31:0] reg_rdata;
  logic [1:0] pin_out;
  logic [1:0] pin_oe;
  int fail_count = 0;
  int total_checks = 0;
  int cycles = 0;
  int n;
  int sum;
  logic lvl;

  // 250 MHz clock
  always #2 clock = ~clock;

  dpf_core u_dpf_core (
    .clock(clock),
    .rst_b(rst_b),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .general_purpose_pin_out(pin_out),
    .general_purpose_pin_oe(pin_oe)
  );

  // Verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t ns: got %h expected %h", $time, got, exp);
    end
  endtask

  // One cycle write strobe; a free edge follows so strobes never collide
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe, so sample there
  task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clock);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    chk(reg_rdata, exp);
  endtask

  // Settled sample point a little after an edge
  task automatic settle(input int k);
    repeat (k) @(posedge clock);
    #1;
  endtask

  // Cycles the pin holds its present level, ending on the first sample of the next
  task automatic seg(input int i, input int lim, output int cnt, output logic lv);
    cnt = 0;
    lv = pin_out[i];
    while (pin_out[i] === lv && cnt < lim) begin
      @(posedge clock);
      #1;
      cnt++;
    end
  endtask

  // Ceiling on run length; the whole sequence needs about 33k cycles
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      fail_count++;
      complete_run();
    end
  end

  // Test sequence
  initial begin
    rst_b = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    repeat (2) @(posedge clock);
    rst_b <= 1'b1;
    settle(1);
    chk({28'h0, pin_oe, pin_out}, 32'h0);
    rdchk(dpf_pkg::ADDR_CTRL, 32'h0);
    rdchk(dpf_pkg::ADDR_PERIOD, dpf_pkg::PERIOD_RST);
    rdchk(dpf_pkg::ADDR_DUTY0, dpf_pkg::DUTY_RST);
    rdchk(dpf_pkg::ADDR_SQFREQ, dpf_pkg::SQFREQ_RST);
    rdchk(8'h1c, 32'h0);
    $display("test reset_values done");
    wr(dpf_pkg::ADDR_DUTY1, 32'ha5a5_5a5a);
    rdchk(dpf_pkg::ADDR_DUTY1, 32'ha5a5_5a5a);
    wr(dpf_pkg::ADDR_PERIOD, 32'hffff_ffff);
    rdchk(dpf_pkg::ADDR_PERIOD, 32'hffff_ffff);
    wr(dpf_pkg::ADDR_CTRL, 32'hffff_fff5);
    rdchk(dpf_pkg::ADDR_CTRL, 32'h5);
    wr(dpf_pkg::ADDR_PERIOD, 32'h4);
    wr(dpf_pkg::ADDR_DUTY0, 32'h1);
    wr(dpf_pkg::ADDR_DUTY1, 32'h4);
    wr(dpf_pkg::ADDR_SQFREQ, 32'd4000000);
    rdchk(dpf_pkg::ADDR_SQFREQ, 32'd4000000);
    wr(dpf_pkg::ADDR_CTRL, 32'h9);
    settle(2);
    chk(32'(pin_oe), 32'h3);
    chk(32'(pin_out[0]), 32'h0);
    $display("test registers done");
    // Eight half periods at 4 MHz make exactly 250 cycles
    seg(1, 1000, n, lvl);
    sum = 0;
    repeat (8) begin
      seg(1, 1000, n, lvl);
      sum += n;
    end
    chk(32'(sum), 32'd250);
    wr(dpf_pkg::ADDR_SQFREQ, 32'd1000000);
    settle(1);
    seg(1, 1000, n, lvl);
    seg(1, 1000, n, lvl);
    seg(1, 1000, n, lvl);
    chk(32'(n), 32'd125);
    seg(1, 1000, n, lvl);
    chk(32'(n), 32'd125);
    wr(dpf_pkg::ADDR_SQFREQ, 32'hffff_ffff);
    settle(1);
    seg(1, 1000, n, lvl);
    seg(1, 1000, n, lvl);
    sum = 0;
    repeat (8) begin
      seg(1, 1000, n, lvl);
      sum += n;
    end
    chk(32'(sum), 32'd250);
    wr(dpf_pkg::ADDR_SQFREQ, 32'h0);
    settle(4);
    seg(1, 500, n, lvl);
    chk({31'h0, lvl}, 32'h0);
    chk(32'(n), 32'd500);
    $display("test square_wave done");
    // New duty stays hidden until the reset period of 100 steps ends
    seg(0, 30000, n, lvl);
    chk(32'(n > 20000), 32'h1);
    seg(0, 2000, n, lvl);
    chk(32'(n), 32'd250);
    seg(0, 2000, n, lvl);
    chk(32'(n), 32'd750);
    wr(dpf_pkg::ADDR_CTRL, 32'h5);
    settle(3);
    seg(1, 1000, n, lvl);
    chk({lvl, 31'(n)}, {1'b1, 31'd1000});
    seg(0, 2000, n, lvl);
    seg(0, 2000, n, lvl);
    chk(32'(n), lvl ? 32'd250 : 32'd750);
    wr(dpf_pkg::ADDR_PERIOD, 32'h2);
    settle(1100);
    seg(0, 2000, n, lvl);
    seg(0, 2000, n, lvl);
    chk(32'(n), 32'd250);
    seg(0, 2000, n, lvl);
    chk(32'(n), 32'd250);
    // Period zero runs at one step, so duty 1 holds the pin high
    wr(dpf_pkg::ADDR_PERIOD, 32'h0);
    settle(600);
    seg(0, 1000, n, lvl);
    chk({lvl, 31'(n)}, {1'b1, 31'd1000});
    wr(dpf_pkg::ADDR_DUTY0, 32'h0);
    settle(600);
    seg(0, 1000, n, lvl);
    chk({lvl, 31'(n)}, {1'b0, 31'd1000});
    chk(32'(pin_out[1]), 32'h1);
    rdchk(dpf_pkg::ADDR_COUNT, 32'h0);
    $display("test pwm done");
    // Reserved and off codes release both pins; status ignores writes
    wr(dpf_pkg::ADDR_CTRL, 32'hf);
    settle(2);
    chk({28'h0, pin_oe, pin_out}, 32'h0);
    wr(dpf_pkg::ADDR_CTRL, 32'h0);
    wr(dpf_pkg::ADDR_STATUS, 32'hffff_ffff);
    rdchk(dpf_pkg::ADDR_STATUS, 32'h0);
    $display("test release done");
    complete_run();
  end
endmodule
`default_nettype wire
